// File: asrp_pkg.sv
// Constants and types for the serial result port of the converter.
// Assumes one 125 MHz clock; the converter core sits on the same clock.
package asrp_pkg;

	// ----------------------------------------
	// Widths and frame
	// ----------------------------------------
	localparam int         RES_W      = 18;
	localparam logic [4:0] FRAME_BITS = 5'h12;
	localparam int         SYNC_W     = 9;
	localparam int         SY_SER     = 8;
	localparam int         SY_COD     = 7;
	localparam int         SY_SCK     = 6;
	localparam int         SY_CHAIN   = 5;
	localparam int         PAR_LO     = 4;
	localparam int         PAR_HI     = 9;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_STAT  = 8'h04;
	localparam logic [7:0] REG_MASK  = 8'h08;
	localparam logic [7:0] REG_RSLT  = 8'h0C;
	localparam logic [7:0] REG_STATE = 8'h10;
	localparam int         CTRL_EN   = 0;
	localparam int         ST_DONE   = 0;
	localparam int         ST_ERR    = 1;
	localparam int         EV_W      = 2;

	typedef enum logic [1:0] {
		ASRP_IDLE = 2'h0,
		ASRP_MSH  = 2'h1,
		ASRP_SLV  = 2'h2
	} asrp_state_t;

	// Field order follows the pin order, lowest pin in the lowest bits.
	typedef struct packed {
		logic       readModeOrChainInput;
		logic       clockInvertSelect;
		logic       frameSyncPolarity;
		logic       clockSourceSelect;
		logic [1:0] clockDividerSelect;
	} asrp_cfg_t;

endpackage

// File: asrp_result_port.sv
// Serial result port of a converter, with APB registers and interrupt.
// Assumes conversion strobes and results arrive on clk; pins are asynchronous.
//
// Our own choices: the register offsets and the APB slave port.
module asrp_result_port
	import asrp_pkg::*;
#(
	parameter int SCLK_HALF = 2
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               ce,
	// APB slave
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	output logic                    irq,
	// Converter core
	input  wire logic               convStart,
	input  wire logic               convDone,
	input  wire logic [RES_W-1:0]   convResult,
	// Straps
	input  wire logic               serialMode,
	input  wire logic               outputCodingSelect,
	// Shared configuration pins, parallel bits 4 to 9
	input  wire logic [5:0]         cfgPinIn,
	output logic      [5:0]         cfgPinOut,
	output logic      [5:0]         cfgPinOe,
	// Serial port
	input  wire logic               sclkIn,
	output logic                    sclkOut,
	output logic                    sclkOe,
	output logic                    resultSerialOutput,
	output logic                    frameSync,
	output logic                    incompleteReadFlag
);
	import asrp_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [SYNC_W-1:0] syncA;
	logic [SYNC_W-1:0] syncB;
	logic              sclkD;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA <= '0;
			syncB <= '0;
			sclkD <= 1'b0;
		end else if (ce) begin
			syncA <= {serialMode, outputCodingSelect, sclkIn, cfgPinIn};
			syncB <= syncA;
			sclkD <= syncB[SY_SCK];
		end
	end

	asrp_cfg_t cfgNow;
	asrp_cfg_t cfgL;
	logic      serialOn;
	logic      chainIn;
	logic      extRise;
	logic      ctrlEn;

	assign cfgNow   = asrp_cfg_t'(syncB[5:0]);
	assign serialOn = syncB[SY_SER];
	assign chainIn  = syncB[SY_CHAIN];
	// The active edge of the host clock flips with the invert pin.
	assign extRise  = (syncB[SY_SCK] ^ cfgL.clockInvertSelect)
		& ~(sclkD ^ cfgL.clockInvertSelect);

	// ----------------------------------------
	// Result holding
	// ----------------------------------------
	logic [RES_W-1:0] resultReg;
	logic             haveResult;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resultReg  <= '0;
			haveResult <= 1'b0;
		end else if (ce && convDone) begin
			resultReg  <= convResult;
			haveResult <= 1'b1;
		end
	end

	function automatic logic [RES_W-1:0] coded(input logic [RES_W-1:0] x);
		coded = x ^ {~syncB[SY_COD], {(RES_W - 1){1'b0}}};
	endfunction

	// ----------------------------------------
	// Serial engine
	// ----------------------------------------
	asrp_state_t      state;
	logic [RES_W-1:0] sh;
	logic [4:0]       cnt;
	logic [7:0]       half;
	logic [7:0]       halfLen;
	logic [1:0]       divEff;
	logic             ph;
	logic             doneEv;
	logic             startM;

	// Only master read-after-convert honours the divider pins.
	assign divEff  = (!cfgL.clockSourceSelect && !cfgL.readModeOrChainInput)
		? cfgL.clockDividerSelect : 2'h0;
	assign halfLen = 8'(SCLK_HALF) << divEff;
	assign startM  = cfgNow.readModeOrChainInput
		? (convStart && haveResult)
		: convDone;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state              <= ASRP_IDLE;
			sh                 <= '0;
			cnt                <= '0;
			half               <= '0;
			ph                 <= 1'b0;
			cfgL               <= '0;
			sclkOut            <= 1'b0;
			sclkOe             <= 1'b0;
			frameSync          <= 1'b0;
			resultSerialOutput <= 1'b0;
			incompleteReadFlag <= 1'b0;
			doneEv             <= 1'b0;
		end else if (ce) begin
			incompleteReadFlag <= 1'b0;
			doneEv             <= 1'b0;
			case (state)
				ASRP_IDLE: begin
					ph        <= 1'b0;
					sclkOe    <= 1'b0;
					cfgL      <= cfgNow;
					sclkOut   <= cfgNow.clockInvertSelect;
					frameSync <= cfgNow.frameSyncPolarity;
					if (serialOn && ctrlEn && cfgNow.clockSourceSelect) begin
						state <= ASRP_SLV;
						cnt   <= FRAME_BITS;
					end else if (serialOn && ctrlEn && startM) begin
						state     <= ASRP_MSH;
						sh        <= coded(cfgNow.readModeOrChainInput ? resultReg : convResult);
						cnt       <= '0;
						half      <= '0;
						sclkOe    <= 1'b1;
						frameSync <= ~cfgNow.frameSyncPolarity;
					end
				end
				ASRP_MSH: begin
					half <= half + 8'h01;
					if (half == halfLen - 8'h01) begin
						half    <= '0;
						ph      <= ~ph;
						sclkOut <= ~ph ^ cfgL.clockInvertSelect;
						if (!ph) begin
							resultSerialOutput <= sh[RES_W-1];
							sh                 <= sh << 1;
							cnt                <= cnt + 5'h01;
						end else if (cnt == FRAME_BITS) begin
							state     <= ASRP_IDLE;
							sclkOe    <= 1'b0;
							frameSync <= cfgL.frameSyncPolarity;
							doneEv    <= 1'b1;
						end
					end
				end
				ASRP_SLV: begin
					sclkOe <= 1'b0;
					if (!serialOn || !ctrlEn || !cfgNow.clockSourceSelect) begin
						state <= ASRP_IDLE;
					end else if (convDone) begin
						// A half-read frame is dropped for the fresh result.
						if (cnt != 5'h00 && cnt < FRAME_BITS) begin
							incompleteReadFlag <= 1'b1;
						end
						sh  <= coded(convResult);
						cnt <= '0;
					end else if (extRise) begin
						resultSerialOutput <= sh[RES_W-1];
						sh                 <= {sh[RES_W-2:0], chainIn};
						if (cnt < FRAME_BITS) begin
							cnt <= cnt + 5'h01;
						end
						if (cnt == FRAME_BITS - 5'h01) begin
							doneEv <= 1'b1;
						end
					end
				end
				default: state <= ASRP_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Parallel pin drive
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfgPinOut <= '0;
			cfgPinOe  <= '0;
		end else if (ce) begin
			cfgPinOut <= resultReg[PAR_HI:PAR_LO];
			cfgPinOe  <= {6{~serialOn}};
		end
	end

	// ----------------------------------------
	// APB registers and interrupt
	// ----------------------------------------
	logic [EV_W-1:0] stat;
	logic [EV_W-1:0] mask;
	logic [EV_W-1:0] next_stat;
	logic            acc;
	logic            hit;

	assign acc = psel && penable && pready;
	assign hit = paddr inside {REG_CTRL, REG_STAT, REG_MASK, REG_RSLT, REG_STATE};

	always_comb begin
		next_stat = stat;
		if (acc && pwrite && paddr == REG_STAT) begin
			next_stat = stat & ~pwdata[EV_W-1:0];
		end
		// Set wins over a clear in the same cycle.
		next_stat[ST_DONE] = next_stat[ST_DONE] | doneEv;
		next_stat[ST_ERR]  = next_stat[ST_ERR] | incompleteReadFlag;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit;
			if (psel && penable && !pready) begin
				case (paddr)
					REG_CTRL:  prdata <= 32'(ctrlEn);
					REG_STAT:  prdata <= 32'(stat);
					REG_MASK:  prdata <= 32'(mask);
					REG_RSLT:  prdata <= 32'(resultReg);
					REG_STATE: prdata <= 32'({serialOn, state, cnt});
					default:   prdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrlEn <= 1'b0;
			mask   <= '0;
			stat   <= '0;
			irq    <= 1'b0;
		end else if (ce) begin
			stat <= next_stat;
			irq  <= |(next_stat & mask);
			if (acc && pwrite && paddr == REG_CTRL) begin
				ctrlEn <= pwdata[CTRL_EN];
			end
			if (acc && pwrite && paddr == REG_MASK) begin
				mask <= pwdata[EV_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_par_drive: assert property (ce && !serialOn |=> cfgPinOe == 6'h3F)
		else $error("parallel pins not driven");
	chk_par_data: assert property (ce && !serialOn |=> cfgPinOut == $past(resultReg[PAR_HI:PAR_LO]))
		else $error("parallel bits wrong");
	chk_div_ignored: assert property (cfgL.clockSourceSelect || cfgL.readModeOrChainInput
		|-> halfLen == 8'(SCLK_HALF))
		else $error("divider used outside master read-after-convert");
	chk_master_clk: assert property (state == ASRP_MSH |-> sclkOe)
		else $error("master clock not driven");
	chk_slave_nodrive: assert property (state == ASRP_SLV |=> !sclkOe)
		else $error("slave drives clock");
	chk_sync_pol: assert property (state == ASRP_MSH |-> frameSync != cfgL.frameSyncPolarity)
		else $error("frame sync not active during frame");
	chk_clk_inv: assert property (state == ASRP_MSH && $past(state) == ASRP_MSH
		|-> sclkOut == (ph ^ cfgL.clockInvertSelect))
		else $error("serial clock inversion wrong");
	chk_err_pulse: assert property (ce && state == ASRP_SLV && serialOn && ctrlEn
		&& cfgNow.clockSourceSelect && convDone && cnt != 5'h00 && cnt < FRAME_BITS
		|=> incompleteReadFlag ##1 !incompleteReadFlag)
		else $error("incomplete read not flagged");
	chk_slave_shift: assert property (ce && state == ASRP_SLV && serialOn && ctrlEn
		&& cfgNow.clockSourceSelect && !convDone && extRise
		|=> resultSerialOutput == $past(sh[RES_W-1]))
		else $error("slave data not shifted");
	chk_rac_start: assert property (ce && state == ASRP_IDLE && serialOn && ctrlEn
		&& !cfgNow.clockSourceSelect && !cfgNow.readModeOrChainInput && !convDone
		|=> state == ASRP_IDLE)
		else $error("read started before conversion end");
	chk_coding: assert property (ce && state == ASRP_IDLE && serialOn && ctrlEn
		&& !cfgNow.clockSourceSelect && startM && !cfgNow.readModeOrChainInput
		|=> sh[RES_W-1] == ($past(convResult[RES_W-1]) ^ !$past(syncB[SY_COD])))
		else $error("output coding wrong");

	cov_master_frame: cover property (state == ASRP_MSH ##1 state == ASRP_IDLE && doneEv);
	cov_slave_error: cover property (incompleteReadFlag);
	cov_irq: cover property (irq);

endmodule

// File: asrp_host_model.sv
// Host serial port model: clocks slave reads and captures data at its sampling edge.
// Assumes the bench clears the capture before each frame it checks and keeps sclkIn idle between frames.
module asrp_host_model (
	// Clock and serial pins
	input  wire logic clk,
	input  wire logic sclkOut,
	input  wire logic sclkOe,
	input  wire logic inv,
	input  wire logic sdata,
	output logic      sclkIn
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	logic [31:0] cap;
	int          nCap;
	logic        sclkPrev;
	logic        oePrev;

	initial sclkIn = 1'b0;

	// Edges are found from values sampled on clk, so the capture never races the
	// device update; the last sampling edge lands with the enable drop and still counts.
	always @(posedge clk) begin
		sclkPrev <= sclkOut;
		oePrev   <= sclkOe;
		if (oePrev === 1'b1 && sclkPrev !== inv && sclkOut === inv) begin
			cap = {cap[30:0], sdata};
			nCap++;
		end
	end

	task automatic clear();
		cap = 32'h0;
		nCap = 0;
	endtask

	// The clock stands still low outside frames; configuration is left alone meanwhile.
	task automatic ext_frame(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			sclkIn <= 1'b1;
			repeat (half) @(posedge clk);
			sclkIn <= 1'b0;
			cap = {cap[30:0], sdata};
			nCap++;
			repeat (half) @(posedge clk);
		end
	endtask
endmodule

// File: adc_serial_result_port_bench.sv
// Self-checking bench for the serial result port, with a host serial model.
// Assumes SCLK_HALF of 2 and the register map of the package.
module adc_serial_result_port_bench import asrp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	typedef struct packed {
		logic       rdMode;
		logic       inv;
		logic       pol;
		logic       code;
		logic [1:0] div;
		logic [17:0] res;
	} asrp_row_t;

	logic             clk, rst_b, psel, penable, pwrite, convStart, convDone, serialMode, coding;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic             pready, pslverr, irq, sclkIn, sclkOut, sclkOe, sdo, fsync, rdErr, slvErr;
	logic [RES_W-1:0] convResult, e;
	logic [5:0]       cfgDrv, cfgPinIn, cfgPinOut, cfgPinOe;
	int               n_mismatch, num_checks, len, bad, k;
	asrp_row_t        r;
	asrp_row_t        rows[4] = '{
		'{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 18'h2A5C3},
		'{1'b0, 1'b0, 1'b1, 1'b1, 2'h2, 18'h15A3C},
		'{1'b1, 1'b1, 1'b1, 1'b0, 2'h3, 18'h3F00E},
		'{1'b1, 1'b1, 1'b0, 1'b1, 2'h1, 18'h0C3F1}
	};

	// The shared pins resolve to the device value wherever it drives them.
	assign cfgPinIn = (cfgPinOe & cfgPinOut) | (~cfgPinOe & cfgDrv);

	asrp_result_port #(.SCLK_HALF(2)) i_asrp_result_port (
		.clk(clk), .rst_b(rst_b), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .convStart(convStart), .convDone(convDone), .convResult(convResult),
		.serialMode(serialMode), .outputCodingSelect(coding), .cfgPinIn(cfgPinIn),
		.cfgPinOut(cfgPinOut), .cfgPinOe(cfgPinOe), .sclkIn(sclkIn), .sclkOut(sclkOut),
		.sclkOe(sclkOe), .resultSerialOutput(sdo), .frameSync(fsync), .incompleteReadFlag(rdErr));

	asrp_host_model i_asrp_host_model (
		.clk(clk), .sclkOut(sclkOut), .sclkOe(sclkOe), .inv(cfgDrv[4]), .sdata(sdo), .sclkIn(sclkIn));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic overrun(input string what);
		n_mismatch++;
		$display("wrong value at %0t: %s timed out", $time, what);
		final_report();
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) overrun("apb");
		rd = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic conv_done(input logic [RES_W-1:0] v);
		@(posedge clk);
		convResult <= v;
		convDone <= 1'b1;
		@(posedge clk);
		convDone <= 1'b0;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{rst_b, psel, penable, pwrite, convStart, convDone, serialMode, coding} = 8'h0;
		{paddr, pwdata, convResult, cfgDrv} = 64'h0;
		repeat (4) @(posedge clk);
		chk(32'({irq, sclkOe, sdo, rdErr}), 32'h0, "reset outputs");
		rst_b <= 1'b1;
		for (int a = 0; a < 5; a++) begin
			apb(8'(4 * a), 1'b0, 32'h0);
			chk(rd, 32'h0, "reset register");
		end
		apb(8'h20, 1'b0, 32'h0);
		chk(rd, 32'h0, "unmapped data");
		chk(32'(slvErr), 32'h1, "unmapped error");
		$display("test reset done");
		conv_done(18'h3C5A5);
		repeat (4) @(posedge clk);
		chk(32'(cfgPinOut), 32'h1A, "parallel bits");
		chk(32'(cfgPinOe), 32'h3F, "parallel enable");
		apb(REG_RSLT, 1'b0, 32'h0);
		chk(rd, 32'h3C5A5, "result register");
		serialMode <= 1'b1;
		repeat (4) @(posedge clk);
		chk(32'(cfgPinOe), 32'h0, "serial enable");
		apb(REG_CTRL, 1'b1, 32'h1);
		apb(REG_MASK, 1'b1, 32'h3);
		$display("test parallel done");
		foreach (rows[i]) begin
			r = rows[i];
			cfgDrv <= {r.rdMode, r.inv, r.pol, 1'b0, r.div};
			coding <= r.code;
			repeat (4) @(posedge clk);
			i_asrp_host_model.clear();
			conv_done(r.res);
			if (r.rdMode) begin
				repeat (2) @(posedge clk);
				chk(32'(sclkOe), 32'h0, "no frame on done");
				convStart <= 1'b1;
				@(posedge clk);
				convStart <= 1'b0;
			end
			for (k = 0; sclkOe !== 1'b1 && k < 50; k++) @(posedge clk);
			if (k >= 50) overrun("frame start");
			len = 0;
			bad = 0;
			while (sclkOe === 1'b1 && len < 2000) begin
				if (fsync !== ~r.pol) bad++;
				@(posedge clk);
				len++;
			end
			if (len >= 2000) overrun("frame end");
			// Status, interrupt and the last capture settle one edge after the frame ends.
			repeat (2) @(posedge clk);
			e = r.res ^ {~r.code, 17'h0};
			chk(32'(len), 32'(2 * int'(FRAME_BITS) * (2 << (r.rdMode ? 0 : r.div))), "frame length");
			chk(32'(bad), 32'h0, "sync active");
			chk(32'(fsync), 32'(r.pol), "sync idle");
			chk(32'(i_asrp_host_model.cap[17:0]), 32'(e), "master data");
			chk(32'(irq), 32'h1, "irq done");
			apb(REG_STAT, 1'b1, 32'h1);
			repeat (2) @(posedge clk);
			chk(32'(irq), 32'h0, "irq cleared");
			$display("test master row %0d done", i);
		end
		cfgDrv <= 6'h24;
		coding <= 1'b0;
		repeat (4) @(posedge clk);
		i_asrp_host_model.clear();
		conv_done(18'h1B2E7);
		i_asrp_host_model.ext_frame(22, 8);
		chk(32'(i_asrp_host_model.cap[21:0]), 32'({18'h1B2E7 ^ 18'h20000, {4{cfgDrv[5]}}}), "slave chain");
		chk(32'(sclkOe), 32'h0, "slave clock pin");
		apb(REG_STAT, 1'b1, 32'h3);
		conv_done(18'h0A5F0);
		i_asrp_host_model.ext_frame(5, 8);
		conv_done(18'h2F0A5);
		for (k = 0; rdErr !== 1'b1 && k < 10; k++) @(posedge clk);
		if (k >= 10) overrun("read error");
		chk(32'(k < 10), 32'h1, "read error pulse");
		apb(REG_STAT, 1'b0, 32'h0);
		chk(rd & 32'h2, 32'h2, "error status");
		chk(32'(irq), 32'h1, "error irq");
		apb(REG_STAT, 1'b1, 32'h3);
		i_asrp_host_model.clear();
		i_asrp_host_model.ext_frame(18, 8);
		chk(32'(i_asrp_host_model.cap[17:0]), 32'h0F0A5, "reloaded data");
		$display("test slave done");
		final_report();
	end
endmodule
